/* logic/iph_link_handshake.sv */
// Link handshake block: AXI4-Lite register slave, control lines out, live status in
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Alert bit interrupts remote computer
// - Receive pending line tracks active read
// - Send pending line tracks active write
// - Control bits zero to three drive lines
// - Status shows local and remote lines
// - Status bit three: remote sending
// - Status bit two: remote receiving
// - Control bit ten selects level or pulse
// - Reset gives pulse mode, short pulse
// - Status readable at card register 32
module iph_link_handshake
  import iph_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire iph_axi_req_t axiReq,
  output iph_axi_rsp_t axiRsp,
  // Link lines toward and from the far card
  output iph_lines_t localLines,
  input wire iph_lines_t remoteLines,
  // Card side pins
  output logic requestEnable,
  output logic senseOut,
  output logic lowerTestBit,
  output logic upperTestBit,
  output logic deviceCommandOut,
  input wire logic commandSenseIn,
  input wire logic transferChannelActive
);
  typedef struct packed {
    logic [15:0] control;
    logic cmdLevel;
    logic cmdFire;
    logic awHeld;
    logic [IPH_ADDR_BITS-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } iph_state_t;

  iph_state_t state_q, state_d;
  iph_lines_t remoteSync;
  logic [1:0] cardSync;
  logic [15:0] statusWord;
  logic doWrite;
  logic doRead;

  // Merge byte-enabled write data into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction

  // Remote lines and card pins cross in through three stages
  iph_line_sync #(.WIDTH(4)) uRemoteSync (
    .clock(clock),
    .resetn(resetn),
    .rawIn(remoteLines),
    .syncOut(remoteSync)
  );

  iph_line_sync #(.WIDTH(2)) uCardSync (
    .clock(clock),
    .resetn(resetn),
    .rawIn({transferChannelActive, commandSenseIn}),
    .syncOut(cardSync)
  );

  // Status word: local lines high, remote lines low; remote lines and card pins live samples, local lines and test bits from control
  always_comb begin
    statusWord = '0;
    statusWord[IPH_ST_LOCAL_LO +: 4] = state_q.control[IPH_CTL_ALERT +: 4];
    statusWord[IPH_ST_REMOTE_LO +: 4] = remoteSync;
    statusWord[IPH_ST_CMD_SENSE] = cardSync[0];
    statusWord[IPH_ST_TEST_LO] = state_q.control[IPH_CTL_TEST_LO];
    statusWord[IPH_ST_CHAN_ACT] = cardSync[1];
    statusWord[IPH_ST_TEST_HI] = state_q.control[IPH_CTL_TEST_HI];
  end

  // Write goes once both address and data are held and no response is pending
  assign doWrite = state_q.awHeld && state_q.wHeld && !state_q.bValid;
  assign doRead = axiReq.arvalid && !state_q.rValid;

  // Bus slave and register updates
  always_comb begin
    state_d = state_q;
    state_d.cmdFire = 1'b0;
    if (axiReq.awvalid && !state_q.awHeld) begin
      state_d.awHeld = 1'b1;
      state_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !state_q.wHeld) begin
      state_d.wHeld = 1'b1;
      state_d.wData = axiReq.wdata;
      state_d.wStrb = axiReq.wstrb;
    end
    if (doWrite) begin
      state_d.awHeld = 1'b0;
      state_d.wHeld = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp = IPH_RESP_OKAY;
      case (state_q.awAddr)
        IPH_ADDR_CONTROL: begin
          state_d.control = merge16(state_q.control, state_q.wData, state_q.wStrb) & IPH_CTL_WMASK;
        end
        IPH_ADDR_CMD: begin
          if (state_q.wStrb[0]) begin
            state_d.cmdLevel = state_q.wData[IPH_CMD_FIRE];
            state_d.cmdFire = state_q.wData[IPH_CMD_FIRE];
          end
        end
        IPH_ADDR_STATUS: begin
          state_d.bResp = IPH_RESP_SLVERR; // Status is read-only
        end
        default: begin
          state_d.bResp = IPH_RESP_SLVERR;
        end
      endcase
    end
    if (state_q.bValid && axiReq.bready) begin
      state_d.bValid = 1'b0;
    end
    if (state_q.rValid && axiReq.rready) begin
      state_d.rValid = 1'b0;
    end
    if (doRead) begin
      state_d.rValid = 1'b1;
      state_d.rResp = IPH_RESP_OKAY;
      case (axiReq.araddr)
        IPH_ADDR_STATUS: state_d.rData = {16'h0000, statusWord};
        IPH_ADDR_CONTROL: state_d.rData = 32'h0000_0000; // Write-only, reads zero
        IPH_ADDR_CMD: state_d.rData = {31'h0000_0000, state_q.cmdLevel};
        default: begin
          state_d.rData = 32'h0000_0000;
          state_d.rResp = IPH_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
      state_q.control <= IPH_CTL_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Bus answers; awready and wready come from the registered held flags, arready from the registered rValid
  assign axiRsp.awready = !state_q.awHeld;
  assign axiRsp.wready = !state_q.wHeld;
  assign axiRsp.bvalid = state_q.bValid;
  assign axiRsp.bresp = state_q.bResp;
  assign axiRsp.arready = !state_q.rValid;
  assign axiRsp.rvalid = state_q.rValid;
  assign axiRsp.rdata = state_q.rData;
  assign axiRsp.rresp = state_q.rResp;

  // Control bits straight to link lines; software owns the handshake meaning
  assign localLines.alert = state_q.control[IPH_CTL_ALERT];
  assign localLines.endWarn = state_q.control[IPH_CTL_END_WARN];
  assign localLines.rxPend = state_q.control[IPH_CTL_RX_PEND];
  assign localLines.txPend = state_q.control[IPH_CTL_TX_PEND];
  assign requestEnable = state_q.control[IPH_CTL_REQ_EN];
  assign senseOut = state_q.control[IPH_CTL_SENSE];
  assign lowerTestBit = state_q.control[IPH_CTL_TEST_LO];
  assign upperTestBit = state_q.control[IPH_CTL_TEST_HI];

  // Command output, pulse after reset unless level is selected
  iph_cmd_pulse uCmd (
    .clock(clock),
    .resetn(resetn),
    .levelMode(state_q.control[IPH_CTL_LEVEL_SEL]),
    .fire(state_q.cmdFire),
    .levelValue(state_q.cmdLevel),
    .cmdOut(deviceCommandOut)
  );

  a_lines_follow: assert property (@(posedge clock) disable iff (!resetn)
    localLines == state_q.control[3:0])
    else $error("link lines differ from control bits");
  a_ctl_write: assert property (@(posedge clock) disable iff (!resetn)
    (doWrite && state_q.awAddr == IPH_ADDR_CONTROL && state_q.wStrb == 4'hF)
      |=> localLines == $past(state_q.wData[3:0]))
    else $error("control write not applied");
  a_alert_out: assert property (@(posedge clock) disable iff (!resetn)
    $rose(localLines.alert) |-> $past(doWrite) && $past(state_q.awAddr) == IPH_ADDR_CONTROL)
    else $error("alert line raised without a control write");
  a_local_status: assert property (@(posedge clock) disable iff (!resetn)
    statusWord[11:8] == localLines)
    else $error("local status field wrong");
  a_remote_send: assert property (@(posedge clock) disable iff (!resetn)
    (remoteLines.txPend [*5]) |-> statusWord[3])
    else $error("remote send not shown");
  a_remote_recv: assert property (@(posedge clock) disable iff (!resetn)
    (!remoteLines.rxPend [*5]) |-> !statusWord[2])
    else $error("remote receive shown wrongly");
  a_status_read: assert property (@(posedge clock) disable iff (!resetn)
    doRead && axiReq.araddr == IPH_ADDR_STATUS |=> axiRsp.rvalid && axiRsp.rdata[15:0] == $past(statusWord))
    else $error("status read wrong");
  a_pulse_default: assert property (@(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> !state_q.control[IPH_CTL_LEVEL_SEL])
    else $error("reset did not select pulse mode");
  a_rx_pend: assert property (@(posedge clock) disable iff (!resetn)
    localLines.rxPend == state_q.control[IPH_CTL_RX_PEND])
    else $error("receive pending line wrong");
  a_tx_pend: assert property (@(posedge clock) disable iff (!resetn)
    localLines.txPend == state_q.control[IPH_CTL_TX_PEND])
    else $error("send pending line wrong");
  a_level_mode: assert property (@(posedge clock) disable iff (!resetn)
    (state_q.control[IPH_CTL_LEVEL_SEL] [*2]) |-> deviceCommandOut == $past(state_q.cmdLevel))
    else $error("level mode output wrong");
  c_write: cover property (@(posedge clock) disable iff (!resetn) doWrite);
  c_read: cover property (@(posedge clock) disable iff (!resetn) doRead && axiReq.araddr == IPH_ADDR_STATUS);
  c_remote: cover property (@(posedge clock) disable iff (!resetn) statusWord[3] && statusWord[2]);
endmodule // iph_link_handshake

/* pkg/iph_pkg.sv */
// Package: register map, field positions, timing and carrier types for the link handshake block
package iph_pkg;
  // Register byte addresses (each register one aligned word)
  localparam logic [7:0] IPH_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] IPH_ADDR_STATUS = 8'h80; // Card register 32, index times four
  localparam logic [7:0] IPH_ADDR_CMD = 8'h04;
  localparam int IPH_STATUS_INDEX = 32;
  localparam int IPH_ADDR_BITS = 8;

  // Control word fields
  localparam int IPH_CTL_ALERT = 0;
  localparam int IPH_CTL_END_WARN = 1;
  localparam int IPH_CTL_RX_PEND = 2;
  localparam int IPH_CTL_TX_PEND = 3;
  localparam int IPH_CTL_SENSE = 4;
  localparam int IPH_CTL_TEST_LO = 7;
  localparam int IPH_CTL_REQ_EN = 8;
  localparam int IPH_CTL_LEVEL_SEL = 10;
  localparam int IPH_CTL_TEST_HI = 15;
  localparam logic [15:0] IPH_CTL_RESET = 16'h0000; // Pulse mode after reset
  localparam logic [15:0] IPH_CTL_WMASK = 16'hFFFF;

  // Status word fields
  localparam int IPH_ST_REMOTE_LO = 0;
  localparam int IPH_ST_LOCAL_LO = 8;
  localparam int IPH_ST_CMD_SENSE = 4;
  localparam int IPH_ST_TEST_LO = 7;
  localparam int IPH_ST_CHAN_ACT = 13;
  localparam int IPH_ST_TEST_HI = 15;

  // Command register field: bit 0 fires a command pulse or sets the level
  localparam int IPH_CMD_FIRE = 0;

  // AXI responses
  localparam logic [1:0] IPH_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPH_RESP_SLVERR = 2'h2;

  // Timing: command pulse
  localparam int IPH_CLK_PERIOD_PS = 10000;
  localparam int IPH_PULSE_PS = 227000;
  localparam int IPH_PULSE_CYC = IPH_PULSE_PS / IPH_CLK_PERIOD_PS; // Rounds down to 22 cycles, 220 ns
  localparam logic [4:0] IPH_PULSE_LAST = 5'(IPH_PULSE_CYC - 1);

  // Four link control lines, in bit order
  typedef struct packed {
    logic txPend;
    logic rxPend;
    logic endWarn;
    logic alert;
  } iph_lines_t;

  // AXI4-Lite request and answer carriers
  typedef struct packed {
    logic [IPH_ADDR_BITS-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [IPH_ADDR_BITS-1:0] araddr;
    logic arvalid;
    logic rready;
  } iph_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } iph_axi_rsp_t;
endpackage

/* logic/iph_line_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module iph_line_sync
  import iph_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } iph_sync_state_t;

  iph_sync_state_t state_q, state_d;

  // Stage one feeds only stage two; agreement filters a single stray sample
  always_comb begin
    state_d = state_q;
    state_d.s1 = rawIn;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.held[i] = state_q.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.held;
endmodule // iph_line_sync

/* logic/iph_cmd_pulse.sv */
// Device-command output generator: fixed-width pulse or held level
`timescale 1ns/1ps
module iph_cmd_pulse
  import iph_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic levelMode,
  input wire logic fire,
  input wire logic levelValue,
  output logic cmdOut
);
  typedef struct packed {
    logic busy;
    logic [4:0] count;
    logic out;
  } iph_pulse_state_t;

  iph_pulse_state_t state_q, state_d;

  // Pulse mode counts a fixed width; level mode follows the stored level
  always_comb begin
    state_d = state_q;
    if (levelMode) begin
      state_d.busy = 1'b0;
      state_d.count = '0;
      state_d.out = levelValue;
    end else if (state_q.busy) begin
      if (state_q.count == IPH_PULSE_LAST) begin
        state_d.busy = 1'b0;
        state_d.out = 1'b0;
      end else begin
        state_d.count = state_q.count + 5'h01;
      end
    end else if (fire) begin
      state_d.busy = 1'b1;
      state_d.count = '0;
      state_d.out = 1'b1;
    end else begin
      state_d.out = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign cmdOut = state_q.out;

  a_pulse_width: assert property (@(posedge clock) disable iff (!resetn)
    (!levelMode && $rose(cmdOut)) |-> (cmdOut && !levelMode) [*8] ##0 1)
    else $error("command pulse too short");
  a_level_follow: assert property (@(posedge clock) disable iff (!resetn)
    (levelMode && $past(levelMode)) |-> cmdOut == $past(levelValue))
    else $error("level mode output does not follow level");
  c_pulse: cover property (@(posedge clock) disable iff (!resetn) $fell(cmdOut) && !levelMode);
endmodule // iph_cmd_pulse

/* testbench/iph_remote_card.sv */
// Behavioural far-side card: drives its four link lines and counts alerts
`timescale 1ns/1ps
module iph_remote_card
  import iph_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic readReq,
  input wire logic writeReq,
  input wire logic lastWord,
  input wire logic alertReq,
  input wire logic alertEnable,
  input wire iph_lines_t localIn,
  output iph_lines_t remoteOut,
  output logic autoFirst,
  output int alertCount
);
  logic alertSeen;
  // Lines move just after an edge, as a real card would drive them
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      remoteOut <= '0;
      alertCount <= 0;
      alertSeen <= 1'b0;
      autoFirst <= 1'b0;
    end else begin
      remoteOut.rxPend <= readReq;
      remoteOut.txPend <= writeReq;
      remoteOut.endWarn <= readReq | lastWord;
      remoteOut.alert <= alertReq;
      alertSeen <= localIn.alert;
      // Sending side picks its first-block auto bit from our end warning
      autoFirst <= writeReq & localIn.endWarn;
      // Only a rising alert counts; host keeps it enabled while busy or scheduling
      if (localIn.alert && !alertSeen && (alertEnable || readReq || writeReq)) begin
        alertCount <= alertCount + 1;
      end
    end
  end
endmodule // iph_remote_card

/* testbench/intercomputer_parallel_handshake_test.sv */
// Self-checking bench for the link handshake block
`timescale 1ns/1ps
module intercomputer_parallel_handshake_test
  import iph_pkg::*;
;
  logic clock, resetn, requestEnable, senseOut, lowerTestBit, upperTestBit, deviceCommandOut;
  logic commandSenseIn, transferChannelActive, rdReq, wrReq, lastWord, alertReq, schedOn, autoFirst;
  iph_axi_req_t axiReq;
  iph_axi_rsp_t axiRsp;
  iph_lines_t localLines, remoteLines;
  int alertCount, n_errors, num_checks, cycles, runLen, alertsExp, ctlModel;
  int expQ[$];
  logic [15:0] lfsr, newCtl;
  logic [31:0] rd;
  logic [1:0] resp;

  iph_link_handshake dut (.clock, .resetn, .axiReq, .axiRsp, .localLines, .remoteLines, .requestEnable,
    .senseOut, .lowerTestBit, .upperTestBit, .deviceCommandOut, .commandSenseIn, .transferChannelActive);
  iph_remote_card farCard (.clock, .resetn, .readReq(rdReq), .writeReq(wrReq), .lastWord, .alertReq,
    .alertEnable(schedOn), .localIn(localLines), .remoteOut(remoteLines), .autoFirst, .alertCount);

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    bit aw;
    bit w;
    @(posedge clock);
    aw = 1'b1;
    w = 1'b1;
    axiReq.awaddr <= a;
    axiReq.awvalid <= 1'b1;
    axiReq.wdata <= {16'h0000, d};
    axiReq.wstrb <= 4'hF;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && axiRsp.awready) begin
        aw = 1'b0;
        axiReq.awvalid <= 1'b0;
      end
      if (w && axiRsp.wready) begin
        w = 1'b0;
        axiReq.wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!axiRsp.bvalid);
    r = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do @(posedge clock); while (!axiRsp.arready);
    axiReq.arvalid <= 1'b0;
    do @(posedge clock); while (!axiRsp.rvalid);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask

  // Status expected from the control model and the far card's requests
  task automatic checkStatus();
    logic [15:0] c;
    c = ctlModel[15:0];
    axiRead(IPH_ADDR_STATUS, rd, resp);
    check("status", rd, {16'h0000, c[15], 1'b0, transferChannelActive, 1'b0, c[3:0], c[7], 2'b00,
      commandSenseIn, wrReq, rdReq, rdReq | lastWord, alertReq});
    check("statusResp", resp, IPH_RESP_OKAY);
    // Host sees a far request whenever the far card is reading or writing
    check("remoteBusy", rd[3] | rd[2], wrReq | rdReq);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pulse widths are judged when the output falls, level mode excluded
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
    if (deviceCommandOut === 1'b1) begin
      runLen++;
    end else begin
      if (runLen > 0 && !ctlModel[10]) begin
        if (expQ.size() == 0) check("extraPulse", 1, 0);
        else check("pulseLen", runLen, expQ.pop_front());
      end
      runLen = 0;
    end
  end

  initial begin
    resetn = 1'b0;
    axiReq = '0;
    {schedOn, commandSenseIn, transferChannelActive, rdReq, wrReq, lastWord, alertReq} = '0;
    lfsr = 16'h1E40;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check("resetLines", {deviceCommandOut, localLines}, 5'h00);
    // Default pulse mode: each fire gives one 220 ns pulse (22 cycles)
    for (int i = 0; i < 2; i++) begin
      expQ.push_back(227 / 10);
      axiWrite(IPH_ADDR_CMD, 16'h0001, resp);
      repeat (30) @(posedge clock);
    end
    axiWrite(IPH_ADDR_CMD, 16'h0000, resp);
    // Level mode follows the stored command bit
    axiWrite(IPH_ADDR_CONTROL, 16'h0400, resp);
    ctlModel = 32'h0400;
    axiWrite(IPH_ADDR_CMD, 16'h0001, resp);
    repeat (30) @(posedge clock);
    check("levelHigh", deviceCommandOut, 1'b1);
    axiRead(IPH_ADDR_CMD, rd, resp);
    check("cmdRead", {resp, rd}, {IPH_RESP_OKAY, 32'h0000_0001});
    axiWrite(IPH_ADDR_CMD, 16'h0000, resp);
    repeat (3) @(posedge clock);
    check("levelLow", deviceCommandOut, 1'b0);
    // Random control words and far-side activity
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsrNext(lfsr);
      newCtl = lfsr;
      // Far card counts a rising alert only while its host keeps it enabled
      if (newCtl[0] && !ctlModel[0] && (schedOn || rdReq || wrReq)) alertsExp++;
      axiWrite(IPH_ADDR_CONTROL, newCtl, resp);
      check("ctlResp", resp, IPH_RESP_OKAY);
      ctlModel = newCtl;
      lfsr = lfsrNext(lfsr);
      {schedOn, commandSenseIn, transferChannelActive, rdReq, wrReq, lastWord, alertReq} <= lfsr[6:0];
      repeat (6) @(posedge clock);
      check("ctlPins", {upperTestBit, lowerTestBit, senseOut, requestEnable, localLines},
        {newCtl[15], newCtl[7], newCtl[4], newCtl[8], newCtl[3:0]});
      check("alerts", alertCount, alertsExp);
      check("autoFirst", autoFirst, wrReq & newCtl[1]);
      checkStatus();
    end
    // Write-only control, unmapped read, refused status write
    axiRead(IPH_ADDR_CONTROL, rd, resp);
    check("ctlRead", rd, 32'h0000_0000);
    axiRead(8'h10, rd, resp);
    check("unmapped", {resp, rd}, {IPH_RESP_SLVERR, 32'h0000_0000});
    axiWrite(IPH_ADDR_STATUS, 16'hFFFF, resp);
    check("statusWrite", resp, IPH_RESP_SLVERR);
    // Line timeout: host drops its pending read and alerts the busy far side
    {schedOn, rdReq, wrReq, lastWord} <= 4'b1010;
    axiWrite(IPH_ADDR_CONTROL, 16'h0104, resp);
    ctlModel = 32'h0104;
    repeat (10) @(posedge clock); // One scaled timeout unit on the line
    if (wrReq || rdReq) alertsExp++; // Remote is active, so it is alerted
    axiWrite(IPH_ADDR_CONTROL, 16'h0101, resp);
    ctlModel = 32'h0101;
    repeat (2) @(posedge clock);
    check("timeoutAlert", alertCount, alertsExp);
    check("timeoutLines", localLines, 4'h1);
    // Interrupts go off only once nothing is pending
    axiWrite(IPH_ADDR_CONTROL, 16'h0000, resp);
    ctlModel = 0;
    check("quietPins", {requestEnable, localLines}, 5'h00);
    checkStatus();
    check("pulsesLeft", expQ.size(), 0);
    end_of_test();
  end
endmodule // intercomputer_parallel_handshake_test
